// file: design/scs_config_status.sv
// spi configuration and status register slice with pin sampling
`default_nettype none

// Behaviour
// - busy bit follows transfer in progress
// - master enable 0 slave, 1 master drives clock
// - phase selects first or second centring edge
// - polarity sets idle level of clock line
// - slave selected from de-glitched select pin
// - raw select pin level readable
// - slave shift empty set when all drained
// - shift empty cleared by load or clock edge
// - shift empty reads one in master
// - receive empty one when buffer read
// - receive empty zero while unread byte
// - receive empty reads one in master
// - slave samples mosi at bit midpoint
// - master samples miso one cycle before end
// - disable unit before changing phase or polarity; not enforced here, phase and polarity writes are taken at any time
// - mode fault clears master and unit enable
module scs_config_status
    import scs_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic      sfr_wr,
    input  wire logic      sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic     [7:0] sfr_rdata,
    input  wire scs_pins_s pins,
    input  wire scs_eng_s  eng,
    input  wire logic      unit_enable,
    output scs_cfg_s       cfg,
    output logic           sck_oe_n,
    output logic           sck_idle,
    output logic           mosi_sample,
    output logic           mosi_bit,
    output logic           miso_sample,
    output logic           miso_bit,
    output logic           sck_edge,
    output logic           mode_fault_flag,
    output logic           unit_enable_clr,
    output logic           slave_selected
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    scs_pins_s sync1_reg;
    scs_pins_s sync2_reg;
    logic      sck_prev_reg;
    scs_cfg_s  cfg_reg;
    scs_cfg_s  cfg_next;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg    <= 4'h4;
            sync2_reg    <= 4'h4;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= pins;
            sync2_reg    <= sync1_reg;
            sck_prev_reg <= sync2_reg.sck;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic sck_any;
    logic lead_edge;
    logic mid_edge;

    always_comb
    begin
        sck_rise  = sync2_reg.sck & ~sck_prev_reg;
        sck_fall  = ~sync2_reg.sck & sck_prev_reg;
        sck_any   = sck_rise | sck_fall;
        lead_edge = cfg_reg.clock_polarity ? sck_fall : sck_rise;
        // data centred on leading edge for phase 0, trailing for 1
        mid_edge  = cfg_reg.clock_phase ? (sck_any & ~lead_edge) : lead_edge;
    end

    // ****************************************************************
    // select de-glitch
    // ****************************************************************
    logic [SCS_DG_W-1:0] dg_cnt_reg;
    logic [SCS_DG_W-1:0] dg_cnt_next;
    logic                sel_reg;
    logic                sel_next;

    always_comb
    begin
        dg_cnt_next = dg_cnt_reg;
        sel_next    = sel_reg;
        if (sync2_reg.slave_select_n == sel_reg)
        begin
            // pin differs from selected state, count stable cycles
            if (dg_cnt_reg == SCS_DG_W'(SCS_DEGLITCH_CYC - 1))
            begin
                dg_cnt_next = '0;
                sel_next    = ~sync2_reg.slave_select_n;
            end
            else
            begin
                dg_cnt_next = dg_cnt_reg + SCS_DG_W'(1);
            end
        end
        else
        begin
            dg_cnt_next = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dg_cnt_reg <= '0;
            sel_reg    <= 1'b0;
        end
        else
        begin
            dg_cnt_reg <= dg_cnt_next;
            sel_reg    <= sel_next;
        end
    end

    // ****************************************************************
    // configuration bits and mode fault
    // ****************************************************************
    logic     fault_reg;
    logic     fault_next;
    logic     cfg_wr;
    logic     cfg_rd;

    always_comb
    begin
        cfg_wr     = sfr_wr & (sfr_addr == SCS_CFG_ADDR);
        cfg_rd     = sfr_rd & (sfr_addr == SCS_CFG_ADDR);
        cfg_next   = cfg_reg;
        fault_next = 1'b0;
        if (cfg_wr)
        begin
            // is software's duty; writes are taken at any time
            cfg_next.master_enable  = sfr_wdata[SCS_BIT_MASTER_ENABLE];
            cfg_next.clock_phase    = sfr_wdata[SCS_BIT_PHASE];
            cfg_next.clock_polarity = sfr_wdata[SCS_BIT_POL];
        end
        // fault beats a concurrent write of master enable
        if (cfg_reg.master_enable & eng.multi_master & ~sync2_reg.slave_select_n
            & unit_enable)
        begin
            cfg_next.master_enable = 1'b0;
            fault_next             = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_reg   <= '0;
            fault_reg <= 1'b0;
        end
        else
        begin
            cfg_reg   <= cfg_next;
            fault_reg <= fault_next;
        end
    end

    // ****************************************************************
    // shift register empty (slave)
    // ****************************************************************
    logic shift_reg_empty_reg;
    logic shift_reg_empty_next;

    always_comb
    begin
        shift_reg_empty_next = shift_reg_empty_reg;
        if (eng.shift_done & ~eng.tx_pending & ~eng.rx_pending)
        begin
            shift_reg_empty_next = 1'b1;
        end
        // a load or clock edge means the register is not idle
        if (eng.tx_load | sck_any)
        begin
            shift_reg_empty_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_reg_empty_reg <= 1'b1;
        end
        else
        begin
            shift_reg_empty_reg <= shift_reg_empty_next;
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    logic [7:0] status;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        status                 = '0;
        status[SCS_BIT_BUSY]   = eng.xfer_active;
        status[SCS_BIT_MASTER_ENABLE]  = cfg_reg.master_enable;
        status[SCS_BIT_PHASE]  = cfg_reg.clock_phase;
        status[SCS_BIT_POL]    = cfg_reg.clock_polarity;
        status[SCS_BIT_SLAVE_SELECTED] = sel_reg;
        status[SCS_BIT_PINRAW] = sync2_reg.slave_select_n;
        status[SCS_BIT_SHIFT_REG_EMPTY]   = cfg_reg.master_enable | shift_reg_empty_reg;
        status[SCS_BIT_RX_BUFFER_EMPTY]  = cfg_reg.master_enable | ~eng.rx_unread;
        rdata_next             = rdata_reg;
        if (cfg_rd)
        begin
            rdata_next = status;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_reg <= SCS_CFG_RESET;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // data sampling and pin control outputs
    // ****************************************************************
    logic mosi_smp_reg;
    logic mosi_smp_next;
    logic mosi_bit_reg;
    logic mosi_bit_next;
    logic miso_smp_reg;
    logic miso_smp_next;
    logic miso_bit_reg;
    logic miso_bit_next;
    logic edge_reg;
    logic oe_n_reg;
    logic idle_reg;

    always_comb
    begin
        mosi_smp_next = 1'b0;
        mosi_bit_next = mosi_bit_reg;
        miso_smp_next = 1'b0;
        miso_bit_next = miso_bit_reg;
        if (~cfg_reg.master_enable & mid_edge)
        begin
            mosi_smp_next = 1'b1;
            mosi_bit_next = sync2_reg.mosi;
        end
        if (cfg_reg.master_enable & eng.master_bit_last)
        begin
            miso_smp_next = 1'b1;
            miso_bit_next = sync2_reg.miso;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mosi_smp_reg <= 1'b0;
            mosi_bit_reg <= 1'b0;
            miso_smp_reg <= 1'b0;
            miso_bit_reg <= 1'b0;
            edge_reg     <= 1'b0;
            oe_n_reg     <= 1'b1;
            idle_reg     <= 1'b0;
        end
        else
        begin
            mosi_smp_reg <= mosi_smp_next;
            mosi_bit_reg <= mosi_bit_next;
            miso_smp_reg <= miso_smp_next;
            miso_bit_reg <= miso_bit_next;
            edge_reg     <= mid_edge;
            oe_n_reg     <= ~cfg_next.master_enable;
            idle_reg     <= cfg_next.clock_polarity;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb
    begin
        sfr_rdata       = rdata_reg;
        cfg             = cfg_reg;
        sck_oe_n        = oe_n_reg;
        sck_idle        = idle_reg;
        mosi_sample     = mosi_smp_reg;
        mosi_bit        = mosi_bit_reg;
        miso_sample     = miso_smp_reg;
        miso_bit        = miso_bit_reg;
        sck_edge        = edge_reg;
        mode_fault_flag = fault_reg;
        unit_enable_clr = fault_reg;
        slave_selected  = sel_reg;
    end

endmodule
`default_nettype wire

// file: design/scs_pkg.sv
// package: constants and types of the spi configuration and status slice
`default_nettype none
package scs_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] SCS_CFG_ADDR   = 8'hA1;
    localparam int         SCS_BIT_BUSY   = 7;
    localparam int         SCS_BIT_MASTER_ENABLE  = 6;
    localparam int         SCS_BIT_PHASE  = 5;
    localparam int         SCS_BIT_POL    = 4;
    localparam int         SCS_BIT_SLAVE_SELECTED = 3;
    localparam int         SCS_BIT_PINRAW = 2;
    localparam int         SCS_BIT_SHIFT_REG_EMPTY   = 1;
    localparam int         SCS_BIT_RX_BUFFER_EMPTY  = 0;
    localparam logic [7:0] SCS_CFG_RESET  = 8'h07;
    localparam logic [7:0] SCS_WR_MASK    = 8'h70;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SCS_CLK_PERIOD_PS   = 5000;
    localparam int SCS_DEGLITCH_MIN_PS = 10000;
    localparam int SCS_DEGLITCH_CYC_I  =
        (SCS_DEGLITCH_MIN_PS + SCS_CLK_PERIOD_PS - 1) / SCS_CLK_PERIOD_PS;
    localparam int SCS_DEGLITCH_CYC    =
        (SCS_DEGLITCH_CYC_I < 1) ? 1 : SCS_DEGLITCH_CYC_I;
    localparam int SCS_DG_W            = 4;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic master_enable;
        logic clock_phase;
        logic clock_polarity;
    } scs_cfg_s;

    typedef struct packed {
        logic sck;
        logic slave_select_n;
        logic mosi;
        logic miso;
    } scs_pins_s;

    typedef struct packed {
        logic xfer_active;
        logic shift_done;
        logic tx_pending;
        logic rx_pending;
        logic tx_load;
        logic rx_unread;
        logic master_bit_last;
        logic multi_master;
    } scs_eng_s;

endpackage
`default_nettype wire

// file: verif/scs_checker.sv
// checker: concurrent assertions on the configuration and status slice
`default_nettype none
module scs_checker
    import scs_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire scs_pins_s  pins,
    input wire scs_eng_s   eng,
    input wire logic       unit_enable,
    input wire scs_cfg_s   cfg,
    input wire logic       sck_oe_n,
    input wire logic       sck_idle,
    input wire logic       mosi_sample,
    input wire logic       miso_sample,
    input wire logic       mode_fault_flag,
    input wire logic       unit_enable_clr,
    input wire logic       slave_selected
);
    // ******************
    // assertions
    // ******************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire rd_hit = sfr_rd && sfr_addr == SCS_CFG_ADDR;
    wire wr_hit = sfr_wr && sfr_addr == SCS_CFG_ADDR;
    sequence s_fault;
        mode_fault_flag && unit_enable_clr;
    endsequence
    sequence s_fault_gone;
        !cfg.master_enable && sck_oe_n ##1 !mode_fault_flag;
    endsequence
    chk_busy_bit: assert property (rd_hit |=> sfr_rdata[7] == $past(eng.xfer_active))
        else $error("busy bit mismatch");
    chk_master_drive: assert property (sck_oe_n == !cfg.master_enable)
        else $error("clock drive enable mismatch");
    chk_idle_level: assert property (sck_idle == cfg.clock_polarity)
        else $error("idle level mismatch");
    chk_master_flags: assert property (rd_hit && cfg.master_enable |=> sfr_rdata[1:0] == 2'h3)
        else $error("master empty flags not set");
    chk_rx_empty: assert property (rd_hit && !cfg.master_enable |=> sfr_rdata[0] == !$past(eng.rx_unread))
        else $error("receive empty mismatch");
    chk_slave_only: assert property ($past(cfg.master_enable) && cfg.master_enable |-> !mosi_sample)
        else $error("mosi sampled in master");
    chk_miso_time: assert property (miso_sample == $past(cfg.master_enable && eng.master_bit_last))
        else $error("miso sample timing");
    chk_fault_clear: assert property (s_fault |-> s_fault_gone)
        else $error("fault did not clear master");
    chk_fault_cause: assert property (mode_fault_flag |-> $past(cfg.master_enable && eng.multi_master && unit_enable))
        else $error("fault without cause");
    chk_write_mask: assert property (wr_hit |=> mode_fault_flag || cfg == $past(sfr_wdata[6:4]))
        else $error("written bits not stored");
    chk_select_state: assert property ($stable(pins.slave_select_n) [*8] |-> slave_selected == !pins.slave_select_n)
        else $error("selected state mismatch");
endmodule
bind scs_config_status scs_checker chk (.*);
`default_nettype wire

// file: verif/scs_peer_model.sv
// peer: external spi master on the serial side
`default_nettype none
module scs_peer_model
(
    output var logic sck,
    output var logic slave_select_n,
    output var logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sck = 1'b0;
        slave_select_n = 1'b1;
        mosi = 1'b0;
    end
    // released mosi shows the inverse of its last bit
    task automatic park(input logic pol, input logic ssn);
        sck = pol;
        slave_select_n = ssn;
        mosi = !mosi;
    endtask
    task automatic send_byte(input logic [7:0] b, input logic pol, input logic pha);
        slave_select_n = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--)
        begin
            if (!pha)
                mosi = b[i];
            #40 sck = !pol;
            if (pha)
                mosi = b[i];
            #40 sck = pol;
        end
        #100 park(pol, 1'b1);
    endtask
endmodule
`default_nettype wire

// file: verif/tb_scs_config_status.sv
// testbench: register access, slave frames, master sampling and mode fault
`default_nettype none
module tb_scs_config_status
    import scs_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, unit_enable = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rx_sh = 8'h00, sfr_rdata;
    scs_eng_s   eng = '0;
    scs_pins_s  pins;
    scs_cfg_s   cfg;
    logic       sck_oe_n, sck_idle, mosi_sample, mosi_bit, miso_sample, miso_bit;
    logic       sck_edge, mode_fault_flag, unit_enable_clr, slave_selected;
    logic       p_sck, p_ssn, p_mosi, p_miso = 1'b0;
    int         n_samp = 0, n_edge = 0, n_base = 0, e_base = 0, n_errors = 0, n_checks = 0;
    assign pins = {p_sck, p_ssn, p_mosi, p_miso};
    scs_config_status uut (.*);
    scs_peer_model peer (.sck(p_sck), .slave_select_n(p_ssn), .mosi(p_mosi));
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (mosi_sample === 1'b1)
        begin
            rx_sh <= {rx_sh[6:0], mosi_bit};
            n_samp <= n_samp + 1;
        end
        if (sck_edge === 1'b1)
        begin
            n_edge <= n_edge + 1;
        end
    end
    // ******************
    // tasks
    // ******************
    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk) #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp);
        tick(1);
        sfr_addr = SCS_CFG_ADDR;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask
    task automatic wait_hi(ref logic s);
        for (int k = 0; k < 200 && s !== 1'b1; k++)
            tick(1);
        if (s !== 1'b1)
        begin
            n_errors++;
            end_of_test();
        end
    endtask
    // ******************
    // sequence
    // ******************
    initial
    begin
        tick(16);
        chk(sfr_rdata, SCS_CFG_RESET);
        nrst = 1'b1;
        tick(4);
        rd(8'h07);
        wr(SCS_CFG_ADDR, 8'hFF);
        chk({3'h0, cfg, sck_oe_n, sck_idle}, 8'h1D);
        rd(8'h77);
        wr(8'hA2, 8'h00);
        rd(8'h77);
        eng.xfer_active = 1'b1;
        rd(8'hF7);
        for (int v = 0; v < 2; v++)
        begin
            p_miso = v[0];
            eng = 8'h02;
            tick(4);
            chk({6'h00, miso_sample, miso_bit}, {7'h01, v[0]});
            eng = 8'h00;
            tick(1);
            chk({7'h00, miso_sample}, 8'h00);
        end
        eng.multi_master = 1'b1;
        unit_enable = 1'b1;
        peer.park(1'b0, 1'b0);
        wait_hi(mode_fault_flag);
        chk({5'h00, unit_enable_clr, cfg.master_enable, sck_oe_n}, 8'h05);
        eng = 8'h00;
        tick(8);
        rd(8'h3B);
        chk({7'h00, slave_selected}, 8'h01);
        peer.park(1'b0, 1'b1);
        tick(8);
        eng = 8'h08;
        tick(1);
        eng = 8'h60;
        tick(1);
        eng = 8'h50;
        tick(1);
        eng = 8'h00;
        rd(8'h35);
        eng = 8'h40;
        tick(1);
        eng = 8'h04;
        rd(8'h36);
        eng = 8'h00;
        rd(8'h37);
        for (int m = 0; m < 4; m++)
        begin
            unit_enable = 1'b0;
            wr(SCS_CFG_ADDR, {2'h0, m[1:0], 4'h0});
            unit_enable = 1'b1;
            chk({7'h00, sck_idle}, {7'h00, m[0]});
            peer.park(m[0], 1'b1);
            tick(8);
            n_base = n_samp;
            e_base = n_edge;
            peer.send_byte(8'h96 ^ 8'(m), m[0], m[1]);
            tick(8);
            chk(rx_sh, 8'h96 ^ 8'(m));
            chk(8'(n_samp - n_base), 8'h08);
            chk(8'(n_edge - e_base), 8'h08);
            rd({2'h0, m[1:0], 4'h5});
        end
        end_of_test();
    end
endmodule
`default_nettype wire
